// [src/pcpd_top.sv]
// Pin-controlled power-down sequencer for a bank of user I/O pads.
// Assumes core logic on ref_clk_in honours freeze_out as a global hold.
`timescale 1ns/1ps
`include "pcpd_defs.svh"
`default_nettype none

// Function
// - Power-down works only when enabled by configuration, and the pin then serves as the sleep request.
// - While sleep is requested all outputs and internal states are held so output data stays valid.
// - An output that is high-impedance when sleep starts stays high-impedance throughout.
// - During sleep every input except the sleep request is blocked from the internal logic.
// - During sleep the pin hold latches stay active and keep each pin at its last level.
// - With power-down enabled the sleep pin never reaches the logic array as a data input.
// - After the request falls the device resumes within 1 us and the board waits that long.
module pcpd_top #(
  parameter int PADS = 32,
  parameter int SLEEP_IDX = 6
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic sleep_enable_in,
  input wire logic [PADS-1:0] pad_in,
  output logic [PADS-1:0] pad_out,
  output logic [PADS-1:0] pad_oe_out,
  input wire logic [PADS-1:0] core_out_in,
  input wire logic [PADS-1:0] core_oe_in,
  output logic [PADS-1:0] array_in_out,
  output logic [PADS-1:0] keep_level_out,
  output logic keep_en_out,
  output logic freeze_out,
  output logic sleep_active_out
);

  localparam int WAKE_CYC = `PCPD_WAKE_CYC;
  // Pin sampling, synchroniser, state change and output register
  // all come out of the wake budget, so outputs are live inside it
  localparam int WAKE_HOLD = WAKE_CYC - `PCPD_SYNC_LAT - 4;
  localparam logic [`PCPD_CNT_W-1:0] WAKE_LOAD = WAKE_HOLD[`PCPD_CNT_W-1:0];

  // ===================================================================
  // Reset release
  logic rst_s1_q;
  logic rst_s2_q;
  logic rstn;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign rstn = rst_s2_q;

  // ===================================================================
  // Pad input synchronisers, enable strap on the top bit
  pcpd_pin_if #(.WIDTH(PADS + 1)) pins_if ();

  assign pins_if.raw = {sleep_enable_in, pad_in};

  pcpd_sync #(.WIDTH(PADS + 1)) u_sync (
    .clk_in(ref_clk_in),
    .rstn_in(rstn),
    .pins(pins_if)
  );

  logic [PADS-1:0] pad_clean;
  logic cfg_en;
  logic sleep_req;

  assign pad_clean = pins_if.clean[PADS-1:0];
  assign cfg_en = pins_if.clean[PADS];
  assign sleep_req = cfg_en & pad_clean[SLEEP_IDX];

  // ===================================================================
  // Sequencer
  pcpd_pkg::pcpd_state_type state_q;
  pcpd_pkg::pcpd_state_type state_d;
  logic [`PCPD_CNT_W-1:0] wake_cnt_q;
  logic [`PCPD_CNT_W-1:0] wake_cnt_d;

  always_comb begin
    state_d = state_q;
    wake_cnt_d = wake_cnt_q;
    case (state_q)
      pcpd_pkg::PCPD_RUN: begin
        if (sleep_req) begin
          state_d = pcpd_pkg::PCPD_SLEEP;
        end
      end
      pcpd_pkg::PCPD_SLEEP: begin
        if (!sleep_req) begin
          state_d = pcpd_pkg::PCPD_WAKE;
          wake_cnt_d = WAKE_LOAD;
        end
      end
      pcpd_pkg::PCPD_WAKE: begin
        if (sleep_req) begin
          state_d = pcpd_pkg::PCPD_SLEEP;
        end else if (wake_cnt_q == '0) begin
          state_d = pcpd_pkg::PCPD_RUN;
        end else begin
          wake_cnt_d = wake_cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = pcpd_pkg::PCPD_RUN;
        wake_cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      state_q <= pcpd_pkg::PCPD_RUN;
      wake_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  logic freeze;
  assign freeze = (state_q != pcpd_pkg::PCPD_RUN);

  // ===================================================================
  // Pad drivers, held while frozen
  logic [PADS-1:0] pad_out_q;
  logic [PADS-1:0] pad_out_d;
  logic [PADS-1:0] pad_oe_q;
  logic [PADS-1:0] pad_oe_d;

  always_comb begin
    if (freeze) begin
      pad_out_d = pad_out_q;
      pad_oe_d = pad_oe_q;
    end else begin
      // Resumes straight from core state, nothing cleared
      pad_out_d = core_out_in;
      pad_oe_d = core_oe_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      pad_out_q <= {PADS{`PCPD_PAD_RST}};
      pad_oe_q <= {PADS{`PCPD_OE_RST}};
    end else begin
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
    end
  end

  // ===================================================================
  // Array inputs, blocked while frozen
  logic [PADS-1:0] array_q;
  logic [PADS-1:0] array_d;

  always_comb begin
    if (freeze) begin
      array_d = array_q;
    end else begin
      array_d = pad_clean;
    end
    if (cfg_en) begin
      array_d[SLEEP_IDX] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      array_q <= {PADS{`PCPD_PAD_RST}};
    end else begin
      array_q <= array_d;
    end
  end

  // ===================================================================
  // Pin keepers, last level kept while frozen
  logic [PADS-1:0] keep_q;
  logic [PADS-1:0] keep_d;

  always_comb begin
    if (freeze) begin
      keep_d = keep_q;
    end else begin
      keep_d = pad_clean;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      keep_q <= {PADS{`PCPD_PAD_RST}};
    end else begin
      keep_q <= keep_d;
    end
  end

  // ===================================================================
  // Freeze flag towards the core
  logic freeze_q;
  logic freeze_d;

  always_comb begin
    freeze_d = freeze;
  end

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      freeze_q <= 1'b0;
    end else begin
      freeze_q <= freeze_d;
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe_out = pad_oe_q;
  assign array_in_out = array_q;
  assign keep_level_out = keep_q;
  assign keep_en_out = 1'b1;
  assign freeze_out = freeze_q;
  assign sleep_active_out = freeze_q;

endmodule

`default_nettype wire

// [src/pcpd_defs.svh]
// Timing constants and reset values for the pin-controlled power-down block.
// Assumes a single 200 MHz reference clock.
`ifndef PCPD_DEFS_SVH
`define PCPD_DEFS_SVH

// =====================================================================
// Clock and wake timing
`define PCPD_CLK_PERIOD_PS 5000
`define PCPD_WAKE_MAX_NS 1000
`define PCPD_WAKE_CYC ((`PCPD_WAKE_MAX_NS * 1000) / `PCPD_CLK_PERIOD_PS)
`define PCPD_SYNC_LAT 3
`define PCPD_CNT_W 8

// =====================================================================
// Reset values
`define PCPD_PAD_RST 1'b0
`define PCPD_OE_RST 1'b0

`endif

// [src/pcpd_pkg.sv]
// Types shared by the power-down block.
// No dependencies.
package pcpd_pkg;

  // ===================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    PCPD_RUN = 2'b00,
    PCPD_SLEEP = 2'b01,
    PCPD_WAKE = 2'b10
  } pcpd_state_type;

endpackage

// [src/pcpd_pin_if.sv]
// Carrier between pad-level inputs and their synchronised copies.
// Driven and read inside the power-down top only.
`timescale 1ns/1ps
`default_nettype none

interface pcpd_pin_if #(
  parameter int WIDTH = 1
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;

  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

`default_nettype wire

// [src/pcpd_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes raw inputs are asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none

module pcpd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  pcpd_pin_if.sync pins
);

  // ===================================================================
  // Stages
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] clean_q;
  logic [WIDTH-1:0] clean_d;

  always_comb begin
    // Change accepted once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= pins.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign pins.clean = clean_q;

endmodule

`default_nettype wire

// [bench/pcpd_board.sv]
// Board model: drives the pads and the sleep pin.
// Assumes the bench clock of the block.
`timescale 1ns/1ps
`default_nettype none
module pcpd_board #(
  parameter int PADS = 32,
  parameter int IDX = 6
) (
  input wire logic clk_in,
  input wire logic [PADS-1:0] data_in,
  output logic [PADS-1:0] pad_out = '0
);
  logic busy = 1'b0;
  always @(posedge clk_in) begin
    if (!busy) begin
      #1 pad_out = data_in & ~(PADS'(1) << IDX);
    end
  end
  task automatic nap(input int n);
    busy = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 pad_out[IDX] = 1'b1;
    repeat (6) @(posedge clk_in);
    #1 pad_out = ~pad_out | (PADS'(1) << IDX);
    repeat (n) @(posedge clk_in);
    #1 pad_out[IDX] = 1'b0;
    repeat (210) @(posedge clk_in);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/pcpd_top_assertions.sv]
// Port checker of the power-down block.
// Bound into every pcpd_top.
`timescale 1ns/1ps
`default_nettype none
module pcpd_chk #(
  parameter int PADS = 32,
  parameter int SLEEP_IDX = 6
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic sleep_enable_in,
  input wire logic [PADS-1:0] pad_in,
  input wire logic [PADS-1:0] pad_out,
  input wire logic [PADS-1:0] pad_oe_out,
  input wire logic [PADS-1:0] array_in_out,
  input wire logic keep_en_out,
  input wire logic freeze_out,
  input wire logic sleep_active_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_held;
    freeze_out && $past(freeze_out);
  endsequence
  property p_keep; keep_en_out; endproperty
  a_keep: assert property (p_keep) else $error("keepers off");
  property p_same; sleep_active_out == freeze_out; endproperty
  a_same: assert property (p_same) else $error("flags split");
  property p_out; s_held |-> $stable(pad_out); endproperty
  a_out: assert property (p_out) else $error("data moved");
  property p_oe; s_held |-> $stable(pad_oe_out); endproperty
  a_oe: assert property (p_oe) else $error("enable moved");
  property p_blk; s_held |-> $stable(array_in_out); endproperty
  a_blk: assert property (p_blk) else $error("input leaked");
  property p_pin;
    sleep_enable_in && $past(sleep_enable_in, 6)
      |-> !array_in_out[SLEEP_IDX];
  endproperty
  a_pin: assert property (p_pin) else $error("pin reached array");
  property p_enter;
    $rose(pad_in[SLEEP_IDX]) && sleep_enable_in |-> ##[4:8] freeze_out;
  endproperty
  a_enter: assert property (p_enter) else $error("no sleep");
  property p_wake;
    $fell(pad_in[SLEEP_IDX]) && freeze_out |-> ##[1:200] !freeze_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake late");
endmodule
bind pcpd_top pcpd_chk #(.PADS(PADS), .SLEEP_IDX(SLEEP_IDX)) u_chk (
  .ref_clk_in, .rstn_in, .sleep_enable_in, .pad_in, .pad_out,
  .pad_oe_out, .array_in_out, .keep_en_out, .freeze_out,
  .sleep_active_out);
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench of the power-down block.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic en = 1'b1;
  logic [31:0] core_d = '0, core_e = '0, data = '0, pads, p_out, p_oe, arr;
  logic [31:0] keep;
  logic [31:0] c, e, d;
  logic [31:0] m = 32'h40;
  logic keep_en, frz, act;
  int failures = 0, compares = 0, seed = 32'h1A7D5A1A;
  initial forever #2.5 clk = ~clk;
  pcpd_board brd (.clk_in(clk), .data_in(data), .pad_out(pads));
  pcpd_top dut (.ref_clk_in(clk), .rstn_in(rstn), .sleep_enable_in(en),
    .pad_in(pads), .pad_out(p_out), .pad_oe_out(p_oe),
    .core_out_in(core_d), .core_oe_in(core_e), .array_in_out(arr),
    .keep_level_out(keep), .keep_en_out(keep_en), .freeze_out(frz),
    .sleep_active_out(act));
  task automatic chk(input string n, input logic [31:0] s, x);
    compares++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic print_verdict;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Tests take about 2000 cycles
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  // ========
  // Scenarios
  initial begin
    tick(2);
    rstn = 1'b1;
    tick(6);
    chk("keep_en", 32'(keep_en), 32'h1);
    for (int k = 0; k < 6; k++) begin
      c = $random(seed);
      e = $random(seed);
      d = (k == 0) ? '1 : $random(seed);
      core_d = c;
      core_e = e;
      data = d;
      tick(8);
      chk("array", arr, d & ~m);
      fork
        brd.nap(40 + k);
        begin
          tick(20);
          core_d = ~c;
          core_e = ~e;
          tick(15);
          chk("held_out", p_out, c);
          chk("held_oe", p_oe, e);
          chk("blocked", arr, d & ~m);
          chk("kept", keep, d | m);
        end
      join
      tick(1);
      chk("awake", 32'(frz), 32'h0);
      chk("resumed", p_out, ~c);
    end
    en = 1'b0;
    tick(6);
    fork
      brd.nap(20);
      begin
        tick(12);
        chk("no_sleep", 32'(frz), 32'h0);
        chk("pin_data", 32'(arr[6]), 32'h1);
      end
    join
    print_verdict();
  end
endmodule
`default_nettype wire
